// File: rtl/cqi_pkg.sv
// Constants and types shared by the completion-queue interrupt block.
// Assumes one 40 MHz clock and a plain address/strobe register port.
package cqi_pkg;
    localparam int NUM_CQ = 8;          // Completion queues tracked
    localparam int CQ_W   = 3;
    localparam int NUM_VEC = 32;        // Most vectors in multi MSI
    localparam int VEC_W  = 5;
    localparam int QPTR_W = 8;          // Head and tail pointer width
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_COAL     = 8'h04;
    localparam logic [7:0] OFS_MASK_SET = 8'h08;
    localparam logic [7:0] OFS_MASK_CLR = 8'h0C;
    localparam logic [7:0] OFS_STAT     = 8'h10;
    localparam logic [7:0] OFS_CQ_CFG   = 8'h40;
    localparam logic [7:0] OFS_CQ_HEAD  = 8'h80;

    // Field positions
    localparam int CTRL_MSIE_BIT = 0;
    localparam int CTRL_MME_LSB  = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CFG_IEN_BIT   = 8;
    localparam int CFG_TAIL_LSB  = 16;
    localparam int COAL_TIME_LSB = 8;

    // Values after reset and limits
    localparam logic [2:0]  MME_MAX    = 3'h5;
    localparam logic [31:0] MASK_RST   = 32'h0000_0000;
    localparam logic [15:0] COAL_RST   = 16'h0000;
    localparam logic [31:0] VEC_ONE    = 32'h0000_0001;

    typedef enum logic [1:0] {
        MODE_PIN    = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_MULTI  = 2'b11,
        MODE_OFF    = 2'b10
    } cqi_mode_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } cqi_state_type;
endpackage

// File: rtl/cqi_vec_if.sv
// Carries masked vector status and mode to the message generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cqi_vec_if;
    logic [31:0]          status;
    cqi_pkg::cqi_mode_type mode;
    logic                 busy;

    modport src (output status, output mode, input busy);
    modport gen (input status, input mode, output busy);
endinterface
`default_nettype wire

// File: rtl/cqi_msi_gen.sv
// Message generator: turns vector status edges into MSI requests.
// Assumes status is already masked and arrives from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module cqi_msi_gen (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    cqi_vec_if.gen                     vec,
    output logic                       msi_req,
    output logic [cqi_pkg::VEC_W-1:0]  msi_vector,
    input  wire logic                  msi_ack
);
    cqi_pkg::cqi_state_type state, next_state;
    logic [31:0] prev, next_prev;
    logic [31:0] pend, next_pend;
    logic [cqi_pkg::VEC_W-1:0] next_msi_vector;
    logic [31:0] rise, low_set, take;
    logic        partial, is_msi;

    // Edge terms; a masked vector never rises, so it never pends
    always_comb begin
        is_msi  = vec.mode == cqi_pkg::MODE_SINGLE ||
                  vec.mode == cqi_pkg::MODE_MULTI;
        rise    = vec.status & ~prev;
        partial = |(prev & ~vec.status) && |vec.status;
        low_set = vec.status & (~vec.status + 32'h0000_0001);
    end

    // Pending set wins over the take of the same bit
    always_comb begin
        next_prev       = vec.status;
        next_state      = state;
        next_msi_vector = msi_vector;
        take            = '0;
        for (int i = cqi_pkg::NUM_VEC - 1; i >= 0; i--) begin
            if (state == cqi_pkg::ST_IDLE && pend[i]) begin
                take            = cqi_pkg::VEC_ONE << i;
                next_msi_vector = cqi_pkg::VEC_W'(i);
            end
        end
        case (state)
            cqi_pkg::ST_IDLE: begin
                if (|pend) begin
                    next_state = cqi_pkg::ST_SEND;
                end
            end
            cqi_pkg::ST_SEND: begin
                if (msi_ack) begin
                    next_state = cqi_pkg::ST_IDLE;
                end
            end
            default: next_state = cqi_pkg::ST_IDLE;
        endcase
        next_pend = (pend & ~take) | rise | (partial ? low_set : '0);
        // Cleared or masked vectors drop what they owed
        next_pend = is_msi ? (next_pend & vec.status) : '0;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state      <= cqi_pkg::ST_IDLE;
            prev       <= '0;
            pend       <= '0;
            msi_vector <= '0;
        end else begin
            state      <= next_state;
            prev       <= next_prev;
            pend       <= next_pend;
            msi_vector <= next_msi_vector;
        end
    end

    assign msi_req  = state == cqi_pkg::ST_SEND;
    assign vec.busy = state == cqi_pkg::ST_SEND || |pend;

    property p_rise_msg;
        @(posedge clock) disable iff (sys_rst)
        is_msi && |rise && state == cqi_pkg::ST_IDLE |=> ##1 msi_req;
    endproperty
    a_rise_msg: assert property (p_rise_msg)
        else $error("rising status bit sent no message");

    property p_partial_msg;
        @(posedge clock) disable iff (sys_rst)
        is_msi && partial && state == cqi_pkg::ST_IDLE |=> ##1 msi_req;
    endproperty
    a_partial_msg: assert property (p_partial_msg)
        else $error("partial clear sent no message");

    property p_none_clear;
        @(posedge clock) disable iff (sys_rst)
        vec.status == '0 && pend == '0 && !msi_req |=> !msi_req;
    endproperty
    a_none_clear: assert property (p_none_clear)
        else $error("message sent with all status clear");

    property p_req_hold;
        @(posedge clock) disable iff (sys_rst)
        msi_req && !msi_ack |=> msi_req && $stable(msi_vector);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("message request dropped before ack");

    c_send: cover property (@(posedge clock) msi_req && msi_ack);
    c_partial: cover property (@(posedge clock) is_msi && partial);
endmodule // cqi_msi_gen
`default_nettype wire

// File: rtl/cqi_irq_ctrl.sv
// Completion-queue interrupt controller: mode select, vector status,
// host mask, legacy wire and MSI message requests.
// Assumes a register master per the plain strobe port and that the
// MSI-X enable arrives from configuration space elsewhere.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cqi_irq_ctrl (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    input  wire logic                   cq_post,
    input  wire logic [2:0]             cq_post_id,
    input  wire logic                   msix_enable,
    output logic                        intx_n,
    output logic                        msi_req,
    output logic [4:0]                  msi_vector,
    input  wire logic                   msi_ack
);
    localparam int NQ = cqi_pkg::NUM_CQ;
    localparam int PW = cqi_pkg::QPTR_W;
    localparam int VW = cqi_pkg::VEC_W;

    // Control state
    logic                msi_enable_bit, next_msi_enable_bit;
    logic [2:0]          msi_vectors_enabled_field, next_mme;
    logic [31:0]         vector_mask_bits, next_mask;
    logic [7:0]          coal_thresh, next_coal_thresh;
    logic [7:0]          coal_time, next_coal_time;
    logic [31:0]         next_rdata;
    logic [PW-1:0]       tail [NQ];
    logic [PW-1:0]       next_tail [NQ];
    logic [PW-1:0]       head [NQ];
    logic [PW-1:0]       next_head [NQ];
    logic [VW-1:0]       cq_vec [NQ];
    logic [VW-1:0]       next_cq_vec [NQ];
    logic [NQ-1:0]       cq_ien, next_cq_ien;

    // Derived state
    logic [31:0]         vector_status_bits, next_status;
    logic                next_intx_n;
    cqi_pkg::cqi_mode_type mode;
    logic [VW-1:0]       vec_lim;
    logic [VW-1:0]       vec_eff [NQ];
    logic [31:0]         cq_hit [NQ];
    logic [NQ-1:0]       cq_unacked;
    logic [31:0]         raw;
    logic                sel_cfg, sel_head;
    logic [2:0]          sel_q;

    cqi_vec_if vec ();

    // Mode select; reserved vector counts fall back to no delivery
    always_comb begin
        if (msix_enable) begin
            mode = cqi_pkg::MODE_OFF;
        end else if (!msi_enable_bit) begin
            mode = cqi_pkg::MODE_PIN;
        end else if (msi_vectors_enabled_field == 3'h0) begin
            mode = cqi_pkg::MODE_SINGLE;
        end else if (msi_vectors_enabled_field <= cqi_pkg::MME_MAX) begin
            mode = cqi_pkg::MODE_MULTI;
        end else begin
            mode = cqi_pkg::MODE_OFF;
        end
    end

    // Usable vector index bits in multi mode, power-of-two count
    assign vec_lim = VW'((6'h01 << msi_vectors_enabled_field) - 6'h01);

    // Per-queue contribution to the raw vector picture
    generate
        for (genvar q = 0; q < NQ; q++) begin : g_cq
            assign cq_unacked[q] = tail[q] != head[q];
            // Pin and single fold every queue onto vector zero
            assign vec_eff[q] = (mode == cqi_pkg::MODE_MULTI) ?
                                (cq_vec[q] & vec_lim) : '0;
            assign cq_hit[q] = (cq_unacked[q] && cq_ien[q]) ?
                               (cqi_pkg::VEC_ONE << vec_eff[q]) : '0;
        end
    endgenerate

    // Status follows queues directly; coalescing is not applied,
    // so the admin queue is never delayed either
    always_comb begin
        raw = '0;
        for (int q = 0; q < NQ; q++) begin
            raw = raw | cq_hit[q];
        end
        next_status = (mode == cqi_pkg::MODE_OFF) ? '0 :
                      (raw & ~vector_mask_bits);
        // Wire low while anything is set in pin mode
        next_intx_n = !(mode == cqi_pkg::MODE_PIN &&
                        |vector_status_bits);
    end

    // Address decode of the queue windows
    always_comb begin
        sel_q    = reg_addr[4:2];
        sel_cfg  = reg_addr[7:5] == cqi_pkg::OFS_CQ_CFG[7:5] &&
                   reg_addr[1:0] == 2'b00;
        sel_head = reg_addr[7:5] == cqi_pkg::OFS_CQ_HEAD[7:5] &&
                   reg_addr[1:0] == 2'b00;
    end

    // Register writes, completion posts and read data
    always_comb begin
        next_msi_enable_bit = msi_enable_bit;
        next_mme            = msi_vectors_enabled_field;
        next_mask           = vector_mask_bits;
        next_coal_thresh    = coal_thresh;
        next_coal_time      = coal_time;
        next_cq_ien         = cq_ien;
        next_rdata          = '0;
        for (int q = 0; q < NQ; q++) begin
            next_tail[q]   = tail[q];
            next_head[q]   = head[q];
            next_cq_vec[q] = cq_vec[q];
        end
        // Posted entry advances the internal tail
        if (cq_post) begin
            next_tail[cq_post_id] = tail[cq_post_id] + PW'(1);
        end
        if (reg_wr) begin
            case (reg_addr)
                cqi_pkg::OFS_CTRL: begin
                    next_msi_enable_bit = reg_wdata[cqi_pkg::CTRL_MSIE_BIT];
                    next_mme = reg_wdata[cqi_pkg::CTRL_MME_LSB +: 3];
                end
                cqi_pkg::OFS_COAL: begin
                    next_coal_thresh = reg_wdata[7:0];
                    next_coal_time =
                        reg_wdata[cqi_pkg::COAL_TIME_LSB +: 8];
                end
                cqi_pkg::OFS_MASK_SET: begin
                    next_mask = vector_mask_bits | reg_wdata;
                end
                cqi_pkg::OFS_MASK_CLR: begin
                    next_mask = vector_mask_bits & ~reg_wdata;
                end
                default: begin
                    if (sel_cfg) begin
                        next_cq_vec[sel_q] = reg_wdata[VW-1:0];
                        next_cq_ien[sel_q] =
                            reg_wdata[cqi_pkg::CFG_IEN_BIT];
                    end else if (sel_head) begin
                        next_head[sel_q] = reg_wdata[PW-1:0];
                    end
                end
            endcase
        end
        // Status vector itself is deliberately absent from reads
        if (reg_rd) begin
            case (reg_addr)
                cqi_pkg::OFS_CTRL: begin
                    next_rdata[cqi_pkg::CTRL_MSIE_BIT] = msi_enable_bit;
                    next_rdata[cqi_pkg::CTRL_MME_LSB +: 3] =
                        msi_vectors_enabled_field;
                    next_rdata[cqi_pkg::CTRL_MODE_LSB +: 2] = mode;
                end
                cqi_pkg::OFS_COAL: begin
                    next_rdata[7:0] = coal_thresh;
                    next_rdata[cqi_pkg::COAL_TIME_LSB +: 8] = coal_time;
                end
                cqi_pkg::OFS_MASK_SET,
                cqi_pkg::OFS_MASK_CLR: begin
                    next_rdata = vector_mask_bits;
                end
                cqi_pkg::OFS_STAT: begin
                    next_rdata[0] = !intx_n;
                    next_rdata[1] = vec.busy;
                end
                default: begin
                    if (sel_cfg) begin
                        next_rdata[VW-1:0] = cq_vec[sel_q];
                        next_rdata[cqi_pkg::CFG_IEN_BIT] = cq_ien[sel_q];
                        next_rdata[cqi_pkg::CFG_TAIL_LSB +: PW] =
                            tail[sel_q];
                    end else if (sel_head) begin
                        next_rdata[PW-1:0] = head[sel_q];
                    end
                end
            endcase
        end
    end

    // Only registers here; all decisions sit in the processes above
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            msi_enable_bit            <= 1'b0;
            msi_vectors_enabled_field <= 3'h0;
            vector_mask_bits          <= cqi_pkg::MASK_RST;
            coal_thresh               <= cqi_pkg::COAL_RST[7:0];
            coal_time                 <= cqi_pkg::COAL_RST[15:8];
            cq_ien                    <= '0;
            reg_rdata                 <= '0;
            vector_status_bits        <= '0;
            intx_n                    <= 1'b1;
            for (int q = 0; q < NQ; q++) begin
                tail[q]   <= '0;
                head[q]   <= '0;
                cq_vec[q] <= '0;
            end
        end else begin
            msi_enable_bit            <= next_msi_enable_bit;
            msi_vectors_enabled_field <= next_mme;
            vector_mask_bits          <= next_mask;
            coal_thresh               <= next_coal_thresh;
            coal_time                 <= next_coal_time;
            cq_ien                    <= next_cq_ien;
            reg_rdata                 <= next_rdata;
            vector_status_bits        <= next_status;
            intx_n                    <= next_intx_n;
            for (int q = 0; q < NQ; q++) begin
                tail[q]   <= next_tail[q];
                head[q]   <= next_head[q];
                cq_vec[q] <= next_cq_vec[q];
            end
        end
    end

    // Hand masked status to the message side
    assign vec.status = vector_status_bits;
    assign vec.mode   = mode;

    cqi_msi_gen u_msi (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .vec        (vec.gen),
        .msi_req    (msi_req),
        .msi_vector (msi_vector),
        .msi_ack    (msi_ack)
    );

    property p_pin_mode;
        @(posedge clock) disable iff (sys_rst)
        !msi_enable_bit && !msix_enable |-> mode == cqi_pkg::MODE_PIN;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("pin mode not selected");

    property p_single_mode;
        @(posedge clock) disable iff (sys_rst)
        msi_enable_bit && !msix_enable &&
        msi_vectors_enabled_field == 3'h0
        |-> mode == cqi_pkg::MODE_SINGLE;
    endproperty
    a_single_mode: assert property (p_single_mode)
        else $error("single message mode not selected");

    property p_multi_mode;
        @(posedge clock) disable iff (sys_rst)
        msi_enable_bit && !msix_enable &&
        msi_vectors_enabled_field inside {[3'h1:3'h5]}
        |-> mode == cqi_pkg::MODE_MULTI;
    endproperty
    a_multi_mode: assert property (p_multi_mode)
        else $error("multiple message mode not selected");

    property p_mask_set;
        @(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == cqi_pkg::OFS_MASK_SET && reg_wdata[0]
        |=> ##1 !vector_status_bits[0];
    endproperty
    a_mask_set: assert property (p_mask_set)
        else $error("masked vector still shows status");

    property p_wire_on;
        @(posedge clock) disable iff (sys_rst)
        mode == cqi_pkg::MODE_PIN && vector_status_bits[0] |=> !intx_n;
    endproperty
    a_wire_on: assert property (p_wire_on)
        else $error("wire not active with status set");

    property p_wire_off;
        @(posedge clock) disable iff (sys_rst)
        vector_status_bits == '0 |=> intx_n;
    endproperty
    a_wire_off: assert property (p_wire_off)
        else $error("wire active with all status clear");

    property p_ack_clear;
        @(posedge clock) disable iff (sys_rst)
        mode == cqi_pkg::MODE_PIN && !cq_post &&
        (cq_ien & cq_unacked) == (8'h01 << sel_q) &&
        reg_wr && sel_head && reg_wdata[PW-1:0] == tail[sel_q]
        |=> ##1 !vector_status_bits[0];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("status stayed set after full acknowledge");

    property p_wire_in_msi;
        @(posedge clock) disable iff (sys_rst)
        mode != cqi_pkg::MODE_PIN |=> intx_n;
    endproperty
    a_wire_in_msi: assert property (p_wire_in_msi)
        else $error("wire driven outside pin mode");

    c_wire: cover property (@(posedge clock) !intx_n);
    c_multi: cover property (@(posedge clock)
        mode == cqi_pkg::MODE_MULTI && msi_req && msi_vector != '0);
endmodule // cqi_irq_ctrl
`default_nettype wire

// File: tb/cqi_host_msi.sv
// Host-side MSI receiver model: accepts each request, fast or slow.
// Assumes the controller holds msi_req until it sees msi_ack.
`timescale 1ns/1ps
`default_nettype none
module cqi_host_msi (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic msi_req,
    input  wire logic slow,
    output logic      msi_ack
);
    logic [1:0] wait_cnt;

    // One-cycle ack; a slow host stalls three cycles first
    always @(posedge clock) begin
        if (sys_rst || !msi_req || msi_ack) begin
            msi_ack  <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (!slow || wait_cnt == 2'h3) begin
            msi_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule // cqi_host_msi
`default_nettype wire

// File: tb/cq_interrupt_status_and_msi_signalling_tb_top.sv
// Self-checking bench for the completion-queue interrupt controller.
// Assumes the host MSI model sits on the message port.
`timescale 1ns/1ps
`default_nettype none
module cq_interrupt_status_and_msi_signalling_tb_top;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        cq_post = 1'b0;
    logic [2:0]  cq_post_id = 3'h0;
    logic        msix_enable = 1'b0;
    logic        slow = 1'b0;
    logic        rd_pend = 1'b0;
    logic [31:0] reg_rdata;
    logic        intx_n;
    logic        msi_req;
    logic        msi_ack;
    logic [4:0]  msi_vector;
    logic [31:0] rnd;
    logic [31:0] rdq[$];
    logic [4:0]  vq[$];
    logic [7:0]  tails[8];
    int          mismatches = 0;
    int          checks = 0;
    int          seed = 36571;

    always #12.5 clock = ~clock;

    cqi_irq_ctrl i_cqi_irq_ctrl (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cq_post(cq_post),
        .cq_post_id(cq_post_id), .msix_enable(msix_enable),
        .intx_n(intx_n), .msi_req(msi_req), .msi_vector(msi_vector),
        .msi_ack(msi_ack));
    cqi_host_msi i_cqi_host_msi (.clock(clock), .sys_rst(sys_rst),
        .msi_req(msi_req), .slow(slow), .msi_ack(msi_ack));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Expected read data is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rdq.push_back(exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask

    // Post one entry, then let any message drain
    task automatic post(input logic [2:0] q);
        @(posedge clock);
        cq_post    <= 1'b1;
        cq_post_id <= q;
        tails[q]++;
        @(posedge clock);
        cq_post <= 1'b0;
        repeat (14) @(posedge clock);
    endtask

    // Head doorbell acknowledges every entry of the queue
    task automatic ack(input logic [2:0] q);
        wr(cqi_pkg::OFS_CQ_HEAD | {3'h0, q, 2'b00},
           {24'h0, tails[q]});
        repeat (14) @(posedge clock);
    endtask

    task automatic cfg(input logic [2:0] q, input logic [4:0] v);
        wr(cqi_pkg::OFS_CQ_CFG | {3'h0, q, 2'b00}, {23'h0, q != 3'h2, 3'h0, v});
    endtask

    // Read data one cycle after the strobe; messages at the ack edge
    always @(posedge clock) begin
        if (rd_pend)
            check(reg_rdata, rdq.pop_front());
        rd_pend = reg_rd;
        if (msi_req === 1'b1 && msi_ack === 1'b1)
            check({27'h0, msi_vector}, vq.size() != 0 ?
                  {27'h0, vq.pop_front()} : 32'hFFFF_FFFF);
    end

    // Cuts a hang short
    initial begin
        repeat (6000) @(posedge clock);
        mismatches++;
        results();
    end

    initial begin
        for (int i = 0; i < 8; i++) tails[i] = 8'h00;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rd(cqi_pkg::OFS_CTRL, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
        rnd = $random(seed);
        wr(cqi_pkg::OFS_COAL, {16'h0, rnd[15:0]});
        rd(cqi_pkg::OFS_COAL, {16'h0, rnd[15:0]});
        wr(cqi_pkg::OFS_MASK_SET, rnd);
        wr(cqi_pkg::OFS_MASK_CLR, 32'h0000_FFFF);
        rd(cqi_pkg::OFS_MASK_CLR, rnd & 32'hFFFF_0000);
        wr(cqi_pkg::OFS_MASK_CLR, 32'hFFFF_FFFF);
        // Every vectors-field value with MSI on
        for (int m = 0; m < 8; m++) begin
            wr(cqi_pkg::OFS_CTRL, 32'(m * 2 + 1));
            rd(cqi_pkg::OFS_CTRL, 32'(m * 2 + 1) | (m == 0 ? 32'h10 :
               m <= 5 ? 32'h30 : 32'h20));
        end
        wr(cqi_pkg::OFS_CTRL, 32'h0000_0000);
        // Pin mode: queue 2 has interrupts off
        cfg(3'h0, 5'h00);
        cfg(3'h1, 5'h05);
        cfg(3'h2, 5'h00);
        post(3'h2);
        check({31'h0, intx_n}, 32'h1);
        rd(cqi_pkg::OFS_CQ_CFG | 8'h08, 32'h0001_0000);
        post(3'h0);
        check({31'h0, intx_n}, 32'h0);
        rd(cqi_pkg::OFS_STAT, 32'h0000_0001);
        post(3'h1);
        ack(3'h0);
        check({31'h0, intx_n}, 32'h0);
        ack(3'h1);
        check({31'h0, intx_n}, 32'h1);
        wr(cqi_pkg::OFS_MASK_SET, 32'h0000_0001);
        post(3'h0);
        check({31'h0, intx_n}, 32'h1);
        wr(cqi_pkg::OFS_MASK_CLR, 32'h0000_0001);
        repeat (6) @(posedge clock);
        check({31'h0, intx_n}, 32'h0);
        ack(3'h0);
        // MSI-X on: nothing delivered at all
        msix_enable <= 1'b1;
        wr(cqi_pkg::OFS_CTRL, 32'h0000_0001);
        post(3'h0);
        check({31'h0, intx_n}, 32'h1);
        ack(3'h0);
        msix_enable <= 1'b0;
        // Single message: every queue folds onto vector zero
        vq.push_back(5'h00);
        post(3'h1);
        check({31'h0, intx_n}, 32'h1);
        ack(3'h1);
        // Multi, four vectors, slow host
        slow <= 1'b1;
        wr(cqi_pkg::OFS_CTRL, 32'h0000_0005);
        cfg(3'h3, 5'h03);
        cfg(3'h5, 5'h06);
        vq.push_back(5'h03);
        post(3'h3);
        vq.push_back(5'h02);
        post(3'h5);
        vq.push_back(5'h02);
        ack(3'h3);
        ack(3'h5);
        wr(cqi_pkg::OFS_MASK_SET, 32'h0000_0008);
        post(3'h3);
        vq.push_back(5'h03);
        wr(cqi_pkg::OFS_MASK_CLR, 32'h0000_0008);
        repeat (14) @(posedge clock);
        ack(3'h3);
        slow <= rnd[16];
        vq.push_back(5'h00);
        post(3'h0);
        ack(3'h0);
        check(32'(vq.size()), 32'h0000_0000);
        // Mid-run reset must drop the mask and the mode again
        wr(cqi_pkg::OFS_MASK_SET, rnd);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) tails[i] = 8'h00;
        rd(cqi_pkg::OFS_MASK_SET, 32'h0000_0000);
        rd(cqi_pkg::OFS_CTRL, 32'h0000_0000);
        check({31'h0, intx_n}, 32'h1);
        check({31'h0, msi_req}, 32'h0);
        results();
    end
endmodule // cq_interrupt_status_and_msi_signalling_tb_top
`default_nettype wire
